// [shared/rbr_defines.svh]
// register map, field positions, opcodes and timing counts for the back-up and reset control
// assumes a 25 MHz machine-cycle clock and a 32-bit AXI4-Lite register bus
`ifndef RBR_DEFINES_SVH
`define RBR_DEFINES_SVH

// register byte offsets
`define RBR_ADDR_INSTR      8'h00
`define RBR_ADDR_STATUS     8'h04
`define RBR_ADDR_WAKE0      8'h08
`define RBR_ADDR_WAKE1      8'h0c
`define RBR_ADDR_WAKE2      8'h10
`define RBR_ADDR_PULLUP0    8'h14
`define RBR_ADDR_PULLUP1    8'h18
`define RBR_ADDR_PULLUP2    8'h1c
`define RBR_ADDR_EXTIRQ     8'h20

// instruction codes written to the instruction register
`define RBR_OP_BACKUP_EN    4'h1
`define RBR_OP_BACKUP_ENTER 4'h2
`define RBR_OP_WDT_RESTART  4'h3
`define RBR_OP_SKIP_PD      4'h4
`define RBR_OP_SEL_CERAMIC  4'h5
`define RBR_OP_SEL_RC       4'h6

// oscillator selection codes
`define RBR_OSC_RING        2'h0
`define RBR_OSC_CERAMIC     2'h1
`define RBR_OSC_RC          2'h2

// status register bit positions
`define RBR_ST_PD_BIT       0
`define RBR_ST_ARMED_BIT    1
`define RBR_ST_WDF_BIT      2
`define RBR_ST_OSC_LSB      4
`define RBR_ST_LOCK_BIT     6

// field positions inside control registers
`define RBR_EXTIRQ_LVL_BIT  2
`define RBR_WAKE1_P13_BIT   3

// reset and back-up values
`define RBR_CTRL_RST        4'h0
`define RBR_SP_INIT         3'h7

// bus responses
`define RBR_RESP_OKAY       2'b00
`define RBR_RESP_SLVERR     2'b10

// oscillator restart wait after wakeup
`define RBR_CLK_PERIOD_NS   40
`define RBR_OSC_RESTART_NS  640
`define RBR_OSC_RESTART_CYC ((`RBR_OSC_RESTART_NS + `RBR_CLK_PERIOD_NS - 1) / `RBR_CLK_PERIOD_NS)

`endif

// [shared/rbr_pkg.sv]
// types shared by the back-up and reset control and its bench
// assumes the constants of rbr_defines.svh
package rbr_pkg;

  // sequencer states
  typedef enum logic [1:0] {
    ST_RESET,
    ST_RUN,
    ST_BACKUP,
    ST_WAKE
  } rbr_state_t;

  // decoded register selector
  typedef enum logic [3:0] {
    REG_NONE,
    REG_INSTR,
    REG_STATUS,
    REG_WAKE0,
    REG_WAKE1,
    REG_WAKE2,
    REG_PU0,
    REG_PU1,
    REG_PU2,
    REG_EXTIRQ
  } rbr_reg_t;

  // wakeup-capable pins, same layout as the pull-up enables
  typedef struct packed {
    logic       dualK;
    logic       dualC;
    logic [1:0] p2;
    logic [3:0] p1;
    logic [3:0] p0;
  } rbr_pins_t;

  // pulses and levels handed to the cpu core
  typedef struct packed {
    logic       cpuHold;
    logic       pcZero;
    logic       backupInit;
    logic       spLoad;
    logic [2:0] spValue;
    logic       portReset;
    logic       portCLatchSet;
    logic       oscRun;
    logic       skipNext;
  } rbr_cpu_t;

endpackage

// [core/rbr_backup_ctrl.sv]
// reset and ram back-up sequencer with an axi4-lite register slave
// assumes sys_clk is the machine-cycle clock, the cpu obeys cpuCtl, and pins are asynchronous
`timescale 1ns/1ps
`include "rbr_defines.svh"

module rbr_backup_ctrl (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // axi4-lite write address and data
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // axi4-lite write response
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // axi4-lite read
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [7:0]        s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  // external pins
  input  wire logic              resetPinN,
  input  wire rbr_pkg::rbr_pins_t wakePins,
  // watchdog, same clock
  input  wire logic              wdtFlagSet,
  input  wire logic              wdtResetReq,
  // to cpu core, ports and clock unit
  output rbr_pkg::rbr_cpu_t      cpuCtl,
  output logic [11:0]            pullupEn,
  output logic [1:0]             oscSel
);

  // whole module state
  typedef struct packed {
    rbr_pkg::rbr_state_t state;
    rbr_pkg::rbr_pins_t  pinSync1;
    rbr_pkg::rbr_pins_t  pinSync2;
    logic                rstSync1;
    logic                rstSync2;
    logic                armed;
    logic                pdFlag;
    logic                wdFlag1;
    logic                oscLocked;
    logic [1:0]          oscSel;
    logic [3:0]          wake0;
    logic [3:0]          wake1;
    logic [3:0]          wake2;
    logic [3:0]          pu0;
    logic [3:0]          pu1;
    logic [3:0]          pu2;
    logic [3:0]          extIrq;
    logic [4:0]          wakeCnt;
    rbr_pkg::rbr_cpu_t   cpu;
    logic [11:0]         pullupEn;
    logic                awTaken;
    logic                wTaken;
    logic [7:0]          awAddr;
    logic [31:0]         wData;
    logic [3:0]          wStrb;
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } rbr_regs_t;

  rbr_regs_t cur_ff;
  rbr_regs_t nxt_cur;

  // address decoder shared by write and read paths
  function automatic rbr_pkg::rbr_reg_t rbrDecode(input logic [7:0] addr);
    rbr_pkg::rbr_reg_t sel;
    sel = rbr_pkg::REG_NONE;
    unique case (addr)
      `RBR_ADDR_INSTR:   sel = rbr_pkg::REG_INSTR;
      `RBR_ADDR_STATUS:  sel = rbr_pkg::REG_STATUS;
      `RBR_ADDR_WAKE0:   sel = rbr_pkg::REG_WAKE0;
      `RBR_ADDR_WAKE1:   sel = rbr_pkg::REG_WAKE1;
      `RBR_ADDR_WAKE2:   sel = rbr_pkg::REG_WAKE2;
      `RBR_ADDR_PULLUP0: sel = rbr_pkg::REG_PU0;
      `RBR_ADDR_PULLUP1: sel = rbr_pkg::REG_PU1;
      `RBR_ADDR_PULLUP2: sel = rbr_pkg::REG_PU2;
      `RBR_ADDR_EXTIRQ:  sel = rbr_pkg::REG_EXTIRQ;
      default:           sel = rbr_pkg::REG_NONE;
    endcase
    return sel;
  endfunction

  // level-sensitive wakeup match on synchronised pins
  logic [11:0] wakeHitVec;
  logic        wakeLvl;
  logic        wakeHit;
  logic [3:0]  wrOp;
  logic        wrDo;
  rbr_pkg::rbr_reg_t wrSel;
  rbr_pkg::rbr_reg_t rdSel;

  // per-pin wakeup terms
  always_comb
  begin
    wakeLvl = cur_ff.extIrq[`RBR_EXTIRQ_LVL_BIT];
    wakeHitVec[3:0] = cur_ff.wake0 & ~cur_ff.pinSync2.p0;
    wakeHitVec[6:4] = cur_ff.wake1[2:0] & ~cur_ff.pinSync2.p1[2:0];
    if (cur_ff.wake1[`RBR_WAKE1_P13_BIT])
    begin
      wakeHitVec[7] = ~cur_ff.pinSync2.p1[3];
    end
    else
    begin
      wakeHitVec[7] = (cur_ff.pinSync2.p1[3] == wakeLvl);
    end
    wakeHitVec[9:8] = cur_ff.wake2[1:0] & ~cur_ff.pinSync2.p2;
    wakeHitVec[10] = cur_ff.wake2[2] & (cur_ff.pinSync2.dualC == wakeLvl);
    wakeHitVec[11] = cur_ff.wake2[3] & (cur_ff.pinSync2.dualK == wakeLvl);
    wakeHit = |wakeHitVec;
  end

  // next-state logic for the bus slave and the sequencer
  always_comb
  begin
    nxt_cur = cur_ff;
    wrSel = rbrDecode(cur_ff.awAddr);
    rdSel = rbrDecode(s_axi_araddr);
    wrDo = cur_ff.awTaken && cur_ff.wTaken && !cur_ff.bvalid;
    wrOp = cur_ff.wData[3:0];

    // two-stage synchronisers
    nxt_cur.pinSync1 = wakePins;
    nxt_cur.pinSync2 = cur_ff.pinSync1;
    nxt_cur.rstSync1 = resetPinN;
    nxt_cur.rstSync2 = cur_ff.rstSync1;

    // one-cycle pulses default low
    nxt_cur.cpu.pcZero = 1'b0;
    nxt_cur.cpu.backupInit = 1'b0;
    nxt_cur.cpu.spLoad = 1'b0;
    nxt_cur.cpu.portCLatchSet = 1'b0;
    nxt_cur.cpu.skipNext = 1'b0;

    // write address and data, either order
    if (s_axi_awvalid && cur_ff.awready)
    begin
      nxt_cur.awTaken = 1'b1;
      nxt_cur.awAddr = s_axi_awaddr;
      nxt_cur.awready = 1'b0;
    end
    if (s_axi_wvalid && cur_ff.wready)
    begin
      nxt_cur.wTaken = 1'b1;
      nxt_cur.wData = s_axi_wdata;
      nxt_cur.wStrb = s_axi_wstrb;
      nxt_cur.wready = 1'b0;
    end

    // register write and response
    if (wrDo)
    begin
      nxt_cur.awTaken = 1'b0;
      nxt_cur.wTaken = 1'b0;
      nxt_cur.bvalid = 1'b1;
      nxt_cur.bresp = (wrSel == rbr_pkg::REG_NONE) ? `RBR_RESP_SLVERR : `RBR_RESP_OKAY;
      if (cur_ff.wStrb[0])
      begin
        unique case (wrSel)
          rbr_pkg::REG_WAKE0:  nxt_cur.wake0 = wrOp;
          rbr_pkg::REG_WAKE1:  nxt_cur.wake1 = wrOp;
          rbr_pkg::REG_WAKE2:  nxt_cur.wake2 = wrOp;
          rbr_pkg::REG_PU0:    nxt_cur.pu0 = wrOp;
          rbr_pkg::REG_PU1:    nxt_cur.pu1 = wrOp;
          rbr_pkg::REG_PU2:    nxt_cur.pu2 = wrOp;
          rbr_pkg::REG_EXTIRQ: nxt_cur.extIrq = wrOp;
          default:             nxt_cur.bresp = nxt_cur.bresp;
        endcase
      end
    end
    if (cur_ff.bvalid && s_axi_bready)
    begin
      nxt_cur.bvalid = 1'b0;
      nxt_cur.awready = 1'b1;
      nxt_cur.wready = 1'b1;
    end

    // register read, pull-ups read as zero
    if (s_axi_arvalid && cur_ff.arready)
    begin
      nxt_cur.arready = 1'b0;
      nxt_cur.rvalid = 1'b1;
      nxt_cur.rdata = 32'h0;
      nxt_cur.rresp = `RBR_RESP_OKAY;
      unique case (rdSel)
        rbr_pkg::REG_STATUS:
        begin
          nxt_cur.rdata[`RBR_ST_PD_BIT] = cur_ff.pdFlag;
          nxt_cur.rdata[`RBR_ST_ARMED_BIT] = cur_ff.armed;
          nxt_cur.rdata[`RBR_ST_WDF_BIT] = cur_ff.wdFlag1;
          nxt_cur.rdata[`RBR_ST_OSC_LSB +: 2] = cur_ff.oscSel;
          nxt_cur.rdata[`RBR_ST_LOCK_BIT] = cur_ff.oscLocked;
        end
        rbr_pkg::REG_WAKE0:  nxt_cur.rdata[3:0] = cur_ff.wake0;
        rbr_pkg::REG_WAKE1:  nxt_cur.rdata[3:0] = cur_ff.wake1;
        rbr_pkg::REG_WAKE2:  nxt_cur.rdata[3:0] = cur_ff.wake2;
        rbr_pkg::REG_EXTIRQ: nxt_cur.rdata[3:0] = cur_ff.extIrq;
        rbr_pkg::REG_NONE:   nxt_cur.rresp = `RBR_RESP_SLVERR;
        default:             nxt_cur.rresp = `RBR_RESP_OKAY;
      endcase
    end
    if (cur_ff.rvalid && s_axi_rready)
    begin
      nxt_cur.rvalid = 1'b0;
      nxt_cur.arready = 1'b1;
    end

    // watchdog flag, set beats restart clear
    if (wrDo && wrSel == rbr_pkg::REG_INSTR && cur_ff.state == rbr_pkg::ST_RUN && cur_ff.wStrb[0]
        && wrOp == `RBR_OP_WDT_RESTART)
    begin
      nxt_cur.wdFlag1 = 1'b0;
    end

    // sequencer
    unique case (cur_ff.state)
      rbr_pkg::ST_RESET:
      begin
        nxt_cur.cpu.cpuHold = 1'b1;
        nxt_cur.cpu.portReset = 1'b1;
        if (cur_ff.rstSync2)
        begin
          nxt_cur.state = rbr_pkg::ST_RUN;
          nxt_cur.cpu.cpuHold = 1'b0;
          nxt_cur.cpu.portReset = 1'b0;
          nxt_cur.cpu.pcZero = 1'b1;
        end
      end
      rbr_pkg::ST_RUN:
      begin
        if (wrDo && wrSel == rbr_pkg::REG_INSTR && cur_ff.wStrb[0])
        begin
          nxt_cur.armed = (wrOp == `RBR_OP_BACKUP_EN);
          if (wrOp == `RBR_OP_BACKUP_ENTER && cur_ff.armed)
          begin
            nxt_cur.state = rbr_pkg::ST_BACKUP;
            nxt_cur.cpu.cpuHold = 1'b1;
            nxt_cur.cpu.oscRun = 1'b0;
            nxt_cur.cpu.backupInit = 1'b1;
            nxt_cur.cpu.spLoad = 1'b1;
            nxt_cur.cpu.portCLatchSet = 1'b1;
            nxt_cur.wdFlag1 = 1'b0;
          end
          if (wrOp == `RBR_OP_SKIP_PD)
          begin
            nxt_cur.cpu.skipNext = cur_ff.pdFlag;
          end
          if ((wrOp == `RBR_OP_SEL_CERAMIC || wrOp == `RBR_OP_SEL_RC) && !cur_ff.oscLocked)
          begin
            nxt_cur.oscLocked = 1'b1;
            nxt_cur.oscSel = (wrOp == `RBR_OP_SEL_RC) ? `RBR_OSC_RC : `RBR_OSC_CERAMIC;
          end
        end
      end
      rbr_pkg::ST_BACKUP:
      begin
        if (wakeHit)
        begin
          nxt_cur.state = rbr_pkg::ST_WAKE;
          nxt_cur.cpu.oscRun = 1'b1;
          nxt_cur.wakeCnt = 5'h0;
        end
      end
      rbr_pkg::ST_WAKE:
      begin
        nxt_cur.wakeCnt = cur_ff.wakeCnt + 5'h1;
        if (cur_ff.wakeCnt == 5'(`RBR_OSC_RESTART_CYC - 1))
        begin
          nxt_cur.state = rbr_pkg::ST_RUN;
          nxt_cur.cpu.cpuHold = 1'b0;
          nxt_cur.cpu.pcZero = 1'b1;
          nxt_cur.pdFlag = 1'b1;
        end
      end
    endcase

    // watchdog flag set wins over the restart and back-up entry clears
    if (wdtFlagSet)
    begin
      nxt_cur.wdFlag1 = 1'b1;
    end

    // reset pin or watchdog reset: cold start; only listed state is touched
    if (!cur_ff.rstSync2 || wdtResetReq)
    begin
      nxt_cur.state = rbr_pkg::ST_RESET;
      nxt_cur.cpu.cpuHold = 1'b1;
      nxt_cur.cpu.portReset = 1'b1;
      nxt_cur.cpu.oscRun = 1'b1;
      nxt_cur.cpu.pcZero = 1'b0;
      nxt_cur.cpu.backupInit = 1'b0;                                             // no entry when reset wins
      nxt_cur.cpu.spLoad = 1'b0;
      nxt_cur.cpu.portCLatchSet = 1'b0;
      nxt_cur.pdFlag = 1'b0;
      nxt_cur.armed = 1'b0;
      nxt_cur.wdFlag1 = 1'b0;
      nxt_cur.oscSel = `RBR_OSC_RING;
      nxt_cur.oscLocked = 1'b0;
      nxt_cur.wake0 = `RBR_CTRL_RST;
      nxt_cur.wake1 = `RBR_CTRL_RST;
      nxt_cur.wake2 = `RBR_CTRL_RST;
      nxt_cur.pu0 = `RBR_CTRL_RST;
      nxt_cur.pu1 = `RBR_CTRL_RST;
      nxt_cur.pu2 = `RBR_CTRL_RST;
      nxt_cur.extIrq = `RBR_CTRL_RST;
    end

    // pull-up enables, off while ports are in reset
    nxt_cur.pullupEn = nxt_cur.cpu.portReset ? 12'h0 : {nxt_cur.pu2, nxt_cur.pu1, nxt_cur.pu0};
  end

  // state register with synchronous reset
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cur_ff <= '0;
      cur_ff.state <= rbr_pkg::ST_RESET;
      cur_ff.oscSel <= `RBR_OSC_RING;
      cur_ff.cpu.cpuHold <= 1'b1;
      cur_ff.cpu.portReset <= 1'b1;
      cur_ff.cpu.oscRun <= 1'b1;
      cur_ff.cpu.spValue <= `RBR_SP_INIT;
      cur_ff.awready <= 1'b1;
      cur_ff.wready <= 1'b1;
      cur_ff.arready <= 1'b1;
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready = cur_ff.awready;
  assign s_axi_wready  = cur_ff.wready;
  assign s_axi_bvalid  = cur_ff.bvalid;
  assign s_axi_bresp   = cur_ff.bresp;
  assign s_axi_arready = cur_ff.arready;
  assign s_axi_rvalid  = cur_ff.rvalid;
  assign s_axi_rdata   = cur_ff.rdata;
  assign s_axi_rresp   = cur_ff.rresp;
  assign cpuCtl        = cur_ff.cpu;
  assign pullupEn      = cur_ff.pullupEn;
  assign oscSel        = cur_ff.oscSel;

endmodule

// [testbench/rbr_backup_monitor.sv]
// assertions on the control outputs of the back-up and reset sequencer
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/1ps
module rbr_backup_monitor (
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              rst_n,
  // control outputs
  input wire rbr_pkg::rbr_cpu_t cpuCtl,
  input wire logic [11:0]       pullupEn,
  input wire logic [1:0]        oscSel
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // oscillator restarted while the cpu still waits
  sequence seq_settle;
    (cpuCtl.oscRun && cpuCtl.cpuHold) [*8];
  endsequence

  // back-up entry pulses and then leaves the oscillator stopped
  sequence seq_enter;
    !cpuCtl.oscRun ##1 (!cpuCtl.spLoad && !cpuCtl.oscRun);
  endsequence

  // reset outputs
  AST_HOLD_IN_RESET: assert property (cpuCtl.portReset |-> cpuCtl.cpuHold)
    else $error("cpu runs while ports are in reset");
  AST_PULLUP_OFF: assert property (cpuCtl.portReset |-> pullupEn == 12'h000)
    else $error("pull-ups on during reset");
  AST_RING_OSC: assert property (cpuCtl.portReset |-> oscSel == 2'h0 && cpuCtl.oscRun)
    else $error("reset not on the on-chip oscillator");
  AST_START_ZERO: assert property ($rose(cpuCtl.pcZero) |-> ##[0:1] (!cpuCtl.cpuHold && !cpuCtl.portReset))
    else $error("start at zero without release of the cpu");
  AST_PC_PULSE: assert property (cpuCtl.pcZero |=> !cpuCtl.pcZero)
    else $error("start pulse longer than one cycle");
  // back-up outputs
  AST_BACKUP_ENTRY: assert property (cpuCtl.spLoad |-> cpuCtl.backupInit && cpuCtl.portCLatchSet && cpuCtl.spValue == 3'h7)
    else $error("back-up entry pulses incomplete");
  AST_OSC_STOP: assert property (cpuCtl.spLoad |-> seq_enter)
    else $error("oscillator not stopped at back-up entry");
  AST_HOLD_IN_BACKUP: assert property (!cpuCtl.oscRun |-> cpuCtl.cpuHold && !cpuCtl.pcZero)
    else $error("cpu runs while the oscillator is stopped");
  AST_WAKE_SETTLE: assert property ($rose(cpuCtl.oscRun) && !cpuCtl.portReset |-> seq_settle ##[6:10] cpuCtl.pcZero)
    else $error("wakeup restart wait wrong");
  AST_SKIP_ONE: assert property (cpuCtl.skipNext |=> !cpuCtl.skipNext)
    else $error("skip result longer than one cycle");
endmodule

bind rbr_backup_ctrl rbr_backup_monitor rbr_backup_monitor_inst (
  .sys_clk  (sys_clk),
  .rst_n    (rst_n),
  .cpuCtl   (cpuCtl),
  .pullupEn (pullupEn),
  .oscSel   (oscSel)
);

// [testbench/rbr_pin_model.sv]
// external reset circuit and key-on wakeup pins
// assumes bench requests change just after a clock edge
`timescale 1ns/1ps
module rbr_pin_model (
  // clock
  input  wire logic               sys_clk,
  // requests from the bench
  input  wire logic               holdReset,
  input  wire rbr_pkg::rbr_pins_t keyLow,
  // pins toward the block
  output logic                    resetPinN,
  output rbr_pkg::rbr_pins_t      wakePins
);
  logic [1:0] lowCnt;

  // idle pins pulled high, reset released
  initial
  begin
    resetPinN = 1'b1;
    wakePins  = 12'hfff;
    lowCnt    = 2'h0;
  end

  // reset pulse stretched over several cycles, keys pull pins low
  always @(posedge sys_clk)
  begin
    if (holdReset)
      lowCnt <= 2'h3;
    else if (lowCnt != 2'h0)
      lowCnt <= lowCnt - 2'h1;
    resetPinN <= !(holdReset || lowCnt != 2'h0);
    wakePins  <= ~keyLow;
  end
endmodule

// [testbench/rbr_backup_ctrl_bench.sv]
// self-checking bench for the back-up and reset sequencer
// assumes the pin model and the bound monitor
`timescale 1ns/1ps
module rbr_backup_ctrl_bench;
  logic               sys_clk, rst_n, awValid, wValid, bReady, arValid, rReady;
  logic               awReady, wReady, bValid, arReady, rValid, resetPinN;
  logic               wdtFlagSet, wdtResetReq, holdReset, skipSeen;
  logic [7:0]         awAddr, arAddr;
  logic [31:0]        wData, rData, d;
  logic [1:0]         bResp, rResp, oscSel, r;
  logic [11:0]        pullupEn;
  logic [3:0]         wStrb;
  rbr_pkg::rbr_pins_t wakePins, keyLow;
  rbr_pkg::rbr_cpu_t  cpuCtl;
  int                 err_total, checks, n;

  rbr_backup_ctrl rbr_backup_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_awaddr(awAddr),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_bresp(bResp),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_araddr(arAddr),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .resetPinN(resetPinN), .wakePins(wakePins), .wdtFlagSet(wdtFlagSet),
    .wdtResetReq(wdtResetReq), .cpuCtl(cpuCtl), .pullupEn(pullupEn), .oscSel(oscSel));
  rbr_pin_model rbr_pin_model_inst (.sys_clk(sys_clk), .holdReset(holdReset),
    .keyLow(keyLow), .resetPinN(resetPinN), .wakePins(wakePins));

  // clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // catch the one-cycle skip result
  always @(posedge sys_clk)
    if (cpuCtl.skipNext)
      skipSeen <= 1'b1;

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(inout int k);
    @(posedge sys_clk);
    k++;
    if (k > 400)
    begin
      err_total++;
      $display("MISMATCH at %0t: wait ran out", $time);
      conclude();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int k;
    k = 0;
    @(posedge sys_clk);
    awValid <= 1'b1;
    awAddr  <= a;
    wValid  <= 1'b1;
    wData   <= v;
    bReady  <= 1'b1;
    do
    begin
      tick(k);
      if (awValid && awReady)
        awValid <= 1'b0;
      if (wValid && wReady)
        wValid <= 1'b0;
    end
    while (!bValid);
    rs = bResp;
    bReady <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int k;
    k = 0;
    @(posedge sys_clk);
    arValid <= 1'b1;
    arAddr  <= a;
    rReady  <= 1'b1;
    do
    begin
      tick(k);
      if (arValid && arReady)
        arValid <= 1'b0;
    end
    while (!rValid);
    v = rData;
    rs = rResp;
    rReady <= 1'b0;
  endtask

  // read and compare the masked bits
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0]  rs;
    rd(a, v, rs);
    check(v & m, e);
  endtask

  task automatic op(input logic [3:0] c);
    logic [1:0] rs;
    wr(8'h00, {28'h0, c}, rs);
    check({30'h0, rs}, 32'h0);
  endtask

  task automatic skipchk(input logic e);
    skipSeen <= 1'b0;
    op(4'h4);
    @(posedge sys_clk);
    check({31'h0, skipSeen}, {31'h0, e});
  endtask

  task automatic wait_pc();
    int k;
    k = 0;
    do
      tick(k);
    while (!cpuCtl.pcZero);
  endtask

  // full back-up round trip woken by the given key
  task automatic backup(input rbr_pkg::rbr_pins_t key);
    op(4'h3);
    op(4'h1);
    op(4'h2);
    check({31'h0, cpuCtl.oscRun}, 32'h0);
    repeat (20) @(posedge sys_clk);
    check({31'h0, cpuCtl.oscRun}, 32'h0);
    keyLow <= key;
    wait_pc();
    keyLow <= 12'h000;
    rdchk(8'h04, 32'h1, 32'h1);
    skipchk(1'b1);
  endtask

  initial
  begin
    {rst_n, awValid, wValid, bReady, arValid, rReady, wdtFlagSet, wdtResetReq} = 8'h00;
    {awAddr, arAddr, wData, holdReset, skipSeen} = 50'h0;
    keyLow = 12'h000;
    wStrb = 4'hf;
    err_total = 0;
    checks = 0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    check({31'h0, cpuCtl.portReset}, 32'h1);
    check({20'h0, pullupEn}, 32'h0);
    check({30'h0, oscSel}, 32'h0);
    wait_pc();
    rdchk(8'h04, 32'h1, 32'h0);
    skipchk(1'b0);
    // wake, pull-up and interrupt control registers
    for (n = 0; n < 6; n++)
    begin
      wr(8'h08 + 8'(4 * n), 32'h8 | n, r);
      rdchk(8'h08 + 8'(4 * n), 32'hffffffff, (n < 3) ? (32'h8 | n) : 32'h0);
    end
    wr(8'h20, 32'h3, r);
    rdchk(8'h20, 32'hffffffff, 32'h3);
    check({20'h0, pullupEn}, 32'hdcb);
    // write with byte lane 0 off stores nothing
    wStrb <= 4'h0;
    wr(8'h08, 32'h5, r);
    wStrb <= 4'hf;
    check({30'h0, r}, 32'h0);
    rdchk(8'h08, 32'hf, 32'h8);
    wr(8'h24, 32'h5, r);
    check({30'h0, r}, 32'h2);
    rd(8'h24, d, r);
    check({r, d[29:0]}, 32'h80000000);
    // first oscillator choice wins
    op(4'h5);
    op(4'h6);
    rdchk(8'h04, 32'h70, 32'h50);
    check({30'h0, oscSel}, 32'h1);
    // lone or interrupted enter is a no-op
    op(4'h2);
    repeat (4) @(posedge sys_clk);
    check({31'h0, cpuCtl.oscRun}, 32'h1);
    op(4'h1);
    rdchk(8'h04, 32'h2, 32'h2);
    op(4'h4);
    op(4'h2);
    repeat (4) @(posedge sys_clk);
    check({31'h0, cpuCtl.oscRun}, 32'h1);
    // watchdog flag set then cleared by restart
    wdtFlagSet <= 1'b1;
    @(posedge sys_clk);
    wdtFlagSet <= 1'b0;
    rdchk(8'h04, 32'h4, 32'h4);
    op(4'h3);
    rdchk(8'h04, 32'h4, 32'h0);
    // warm starts from a port 0 key and the port 1 pin
    backup(12'h008);
    rdchk(8'h08, 32'hf, 32'h8);
    check({20'h0, pullupEn}, 32'hdcb);
    check({30'h0, oscSel}, 32'h1);
    backup(12'h080);
    // pin reset gives a cold start
    holdReset <= 1'b1;
    @(posedge sys_clk);
    holdReset <= 1'b0;
    n = 0;
    while (!cpuCtl.portReset)
      tick(n);
    check({20'h0, pullupEn}, 32'h0);
    wait_pc();
    rdchk(8'h04, 32'h1, 32'h0);
    rdchk(8'h08, 32'hf, 32'h0);
    check({30'h0, oscSel}, 32'h0);
    // interrupt pin wake at the low level, then watchdog reset
    backup(12'h080);
    wdtResetReq <= 1'b1;
    @(posedge sys_clk);
    wdtResetReq <= 1'b0;
    wait_pc();
    rdchk(8'h04, 32'h1, 32'h0);
    conclude();
  end
endmodule
